// ---- rtl/dhs_consts.vh ----
`ifndef DHS_CONSTS_VH
`define DHS_CONSTS_VH

// register byte offsets
`define DHS_OFF_CTRL 8'h00
`define DHS_OFF_STAT 8'h04
`define DHS_OFF_SHIFT 8'h08
`define DHS_OFF_MOTION 8'h0c

// control register fields
`define DHS_CTRL_START_BIT 4
`define DHS_CTRL_METHOD_LSB 8
`define DHS_CTRL_METHOD_MSB 15
`define DHS_CTRL_SWLIM_BIT 16
`define DHS_CTRL_RESET_VAL 32'h0000_0000

// status register fields
`define DHS_STAT_TARGET_BIT 10
`define DHS_STAT_ATTAINED_BIT 12
`define DHS_STAT_FAULT_BIT 13
`define DHS_STAT_STATE_LSB 16

// method codes (two's complement, 8 bit)
`define DHS_M_REAR_FWD 8'hfa
`define DHS_M_FRONT_FWD 8'hf9
`define DHS_M_CRADLE_FWD 8'hf8
`define DHS_M_REAR_REV 8'hda
`define DHS_M_FRONT_REV 8'hd9
`define DHS_M_CRADLE_REV 8'hd8

// fault code reported with the homing fault
`define DHS_FAULT_CODE 12'h090

// tolerance figures at creep 100 r/min
`define DHS_TOL_CREEP_RPM 100
`define DHS_TOL_DIVISOR 65536

// speed commands
`define DHS_SPD_STOP 2'h0
`define DHS_SPD_HOMING 2'h1
`define DHS_SPD_CREEP 2'h2

`endif

// ---- rtl/dhs_edge_det.v ----
`timescale 1ns/10ps
// rising/falling edge detector for a synchronous level
module dhs_edge_det (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // level in, edges out
    input wire level_i,
    output wire rise_o,
    output wire fall_o
);
    reg prev_reg;

    // previous sample of the level
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_i;
        end
    end

    // edge pulses
    assign rise_o = level_i & ~prev_reg;
    assign fall_o = ~level_i & prev_reg;
endmodule

// ---- rtl/dhs_sequencer.v ----
`timescale 1ns/10ps
`include "dhs_consts.vh"

module dhs_sequencer #(
    parameter SHIFT_W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire wb_err_o,
    // machine inputs
    input wire dog_i,
    input wire stroke_end_i,
    input wire at_creep_i,
    input wire motion_done_i,
    input wire [SHIFT_W-1:0] travel_count_i,
    // motion commands
    output reg [1:0] speed_cmd_o,
    output reg dir_rev_o,
    output reg home_latch_o,
    output reg homing_fault_alarm_o
);
    // sequencer states
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_BACKOUT = 4'h1;
    localparam [3:0] ST_SEARCH = 4'h2;
    localparam [3:0] ST_IN_DOG = 4'h3;
    localparam [3:0] ST_SHIFT = 4'h4;
    localparam [3:0] ST_STOP = 4'h5;
    localparam [3:0] ST_DONE = 4'h6;
    localparam [3:0] ST_FAULT = 4'h7;
    localparam [3:0] ST_STROKE = 4'h8;

    // software registers and sequencer state
    reg [31:0] ctrl_reg;
    reg [SHIFT_W-1:0] shift_reg;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg start_prev_reg;
    reg ack_reg;
    reg target_reg;
    reg attained_reg;
    reg fault_reg;
    reg [SHIFT_W-1:0] base_reg;
    reg rev_flip_reg;
    reg [31:0] rd_data;

    // decoded fields and strobes
    wire dog_rise;
    wire dog_fall;
    wire [7:0] method;
    wire start_bit;
    wire swlim;
    wire valid_method;
    wire dir_base;
    wire [1:0] kind;
    wire start_pulse;
    wire wb_req;
    wire wb_wr;
    wire adr_ok;
    wire [SHIFT_W-1:0] travelled;

    // dog edge detection, one sample per clock
    dhs_edge_det u_dog_edge (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .level_i(dog_i),
        .rise_o(dog_rise),
        .fall_o(dog_fall)
    );

    assign method = ctrl_reg[`DHS_CTRL_METHOD_MSB:`DHS_CTRL_METHOD_LSB];
    assign start_bit = ctrl_reg[`DHS_CTRL_START_BIT];
    assign swlim = ctrl_reg[`DHS_CTRL_SWLIM_BIT];
    // method decode: kind 1 rear, 2 front, 3 cradle; reverse variants
    assign kind = (method == `DHS_M_REAR_FWD || method == `DHS_M_REAR_REV) ? 2'd1 :
                  (method == `DHS_M_FRONT_FWD || method == `DHS_M_FRONT_REV) ? 2'd2 :
                  (method == `DHS_M_CRADLE_FWD || method == `DHS_M_CRADLE_REV) ? 2'd3 : 2'd0;
    assign valid_method = (kind != 2'd0);
    // reversed codes sit 32 below the base codes
    assign dir_base = (method == `DHS_M_REAR_REV) | (method == `DHS_M_FRONT_REV) |
                      (method == `DHS_M_CRADLE_REV);
    assign start_pulse = start_bit & ~start_prev_reg;
    assign travelled = travel_count_i - base_reg;

    // bus decode
    assign wb_req = wb_cyc_i & wb_stb_i;
    // writes land at the edge where the acknowledge is sampled
    assign wb_wr = wb_req & wb_we_i & ack_reg;
    assign adr_ok = (wb_adr_i == `DHS_OFF_CTRL) | (wb_adr_i == `DHS_OFF_STAT) |
                    (wb_adr_i == `DHS_OFF_SHIFT) | (wb_adr_i == `DHS_OFF_MOTION);
    assign wb_ack_o = ack_reg & adr_ok;
    assign wb_err_o = ack_reg & ~adr_ok;

    // one-cycle-late acknowledge, dropped between requests
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
        end
    end

    // writable registers with byte enables
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= `DHS_CTRL_RESET_VAL;
            shift_reg <= {SHIFT_W{1'b0}};
        end else if (wb_wr) begin
            if (wb_adr_i == `DHS_OFF_CTRL) begin
                if (wb_sel_i[0]) ctrl_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ctrl_reg[15:8] <= wb_dat_i[15:8];
                if (wb_sel_i[2]) ctrl_reg[23:16] <= {7'h00, wb_dat_i[16]};
            end
            if (wb_adr_i == `DHS_OFF_SHIFT) begin
                if (wb_sel_i[0]) shift_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1]) shift_reg[SHIFT_W-1:8] <= wb_dat_i[SHIFT_W-1:8];
            end
        end
    end

    // read mux
    always @* begin
        rd_data = 32'h0000_0000;
        case (wb_adr_i)
            `DHS_OFF_CTRL: rd_data = ctrl_reg;
            `DHS_OFF_STAT: begin
                rd_data[`DHS_STAT_TARGET_BIT] = target_reg;
                rd_data[`DHS_STAT_ATTAINED_BIT] = attained_reg;
                rd_data[`DHS_STAT_FAULT_BIT] = fault_reg;
                rd_data[`DHS_STAT_STATE_LSB+3:`DHS_STAT_STATE_LSB] = state_reg;
                rd_data[31:20] = fault_reg ? `DHS_FAULT_CODE : 12'h000;
            end
            `DHS_OFF_SHIFT: rd_data[SHIFT_W-1:0] = shift_reg;
            `DHS_OFF_MOTION: rd_data[SHIFT_W-1:0] = travelled;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // read data captured when the request is taken, stands with ack
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !ack_reg) begin
            wb_dat_o <= rd_data;
        end
    end

    // next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start_pulse && valid_method) begin
                    if (dog_i) begin
                        state_next = ST_BACKOUT;
                    end else begin
                        state_next = ST_SEARCH;
                    end
                end
            end
            ST_BACKOUT: begin
                // back out against homing direction until dog clears
                if (!dog_i) state_next = ST_SEARCH;
            end
            ST_SEARCH: begin
                if (dog_rise) begin
                    // front end: dog leading edge fixes the reference
                    if (kind == 2'd2) state_next = ST_SHIFT;
                    else state_next = ST_IN_DOG;
                end else if (stroke_end_i) begin
                    if (swlim) state_next = ST_FAULT;
                    else state_next = ST_STROKE;
                end
            end
            ST_STROKE: begin
                // travel back past the dog, then retry from before it
                if (dog_fall) state_next = ST_SEARCH;
            end
            ST_IN_DOG: begin
                if (dog_fall) begin
                    if (!at_creep_i) state_next = ST_FAULT;
                    else state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (travelled >= shift_reg) state_next = ST_STOP;
            end
            ST_STOP: begin
                if (motion_done_i) state_next = ST_DONE;
            end
            ST_DONE: begin
                // a fresh start rise re-runs the whole sequence
                if (start_pulse && valid_method) begin
                    if (dog_i) state_next = ST_BACKOUT;
                    else state_next = ST_SEARCH;
                end
            end
            ST_FAULT: begin
                // fault is left only by a fresh start rise
                if (start_pulse && valid_method) begin
                    if (dog_i) state_next = ST_BACKOUT;
                    else state_next = ST_SEARCH;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // state, flags and motion outputs
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            start_prev_reg <= 1'b0;
            target_reg <= 1'b0;
            attained_reg <= 1'b0;
            fault_reg <= 1'b0;
            base_reg <= {SHIFT_W{1'b0}};
            rev_flip_reg <= 1'b0;
            speed_cmd_o <= `DHS_SPD_STOP;
            dir_rev_o <= 1'b0;
            home_latch_o <= 1'b0;
            homing_fault_alarm_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_prev_reg <= start_bit;
            home_latch_o <= 1'b0;
            if (state_reg != ST_SHIFT && state_next == ST_SHIFT) begin
                base_reg <= travel_count_i; // reference captured at the dog edge
                home_latch_o <= 1'b1;
            end
            // direction keeps the held flip unless the next state sets it,
            // so no cycle is driven the wrong way on a reversal
            dir_rev_o <= dir_base ^ rev_flip_reg;
            case (state_next)
                ST_BACKOUT: begin
                    rev_flip_reg <= 1'b1;
                    speed_cmd_o <= `DHS_SPD_CREEP;
                    dir_rev_o <= ~dir_base;
                end
                ST_STROKE: begin
                    rev_flip_reg <= 1'b1;
                    speed_cmd_o <= `DHS_SPD_HOMING;
                    dir_rev_o <= ~dir_base;
                end
                ST_SEARCH: begin
                    rev_flip_reg <= 1'b0;
                    speed_cmd_o <= `DHS_SPD_HOMING;
                    dir_rev_o <= dir_base;
                end
                ST_IN_DOG: speed_cmd_o <= `DHS_SPD_CREEP;
                ST_SHIFT: speed_cmd_o <= `DHS_SPD_CREEP;
                default: speed_cmd_o <= `DHS_SPD_STOP;
            endcase
            if (start_pulse && valid_method) begin
                target_reg <= 1'b0;
                attained_reg <= 1'b0;
                fault_reg <= 1'b0;
                homing_fault_alarm_o <= 1'b0;
            end
            if (state_next == ST_DONE) begin
                target_reg <= 1'b1;
                attained_reg <= 1'b1;
            end
            if (state_next == ST_FAULT && state_reg != ST_FAULT) begin
                fault_reg <= 1'b1;
                homing_fault_alarm_o <= 1'b1;
                target_reg <= 1'b1;
            end
        end
    end
endmodule

// ---- dv/dhs_sequencer_asserts.sv ----
`timescale 1ns/10ps
`include "dhs_consts.vh"
module dhs_sequencer_asserts #(
    parameter SHIFT_W = 16
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire wb_err_o,
    // machine
    input wire dog_i,
    input wire stroke_end_i,
    input wire at_creep_i,
    input wire motion_done_i,
    input wire [SHIFT_W-1:0] travel_count_i,
    input wire [1:0] speed_cmd_o,
    input wire dir_rev_o,
    input wire home_latch_o,
    input wire homing_fault_alarm_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // address decode and status reads
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire mapped = wb_adr_i[7:4] == 4'h0 && wb_adr_i[1:0] == 2'h0;
    wire st_rd = wb_ack_o && wb_adr_i == `DHS_OFF_STAT;
    property p_answer; req |=> wb_ack_o || wb_err_o; endproperty
    a_answer: assert property (p_answer) else $error("no bus answer");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_decode; (wb_ack_o |-> mapped) and (wb_err_o |-> !mapped); endproperty
    a_decode: assert property (p_decode) else $error("bad decode");
    property p_latch_pulse; home_latch_o |=> !home_latch_o; endproperty
    a_latch_pulse: assert property (p_latch_pulse) else $error("latch too long");
    property p_latch_edge;
        home_latch_o |-> !$stable(dog_i) || $past(dog_i) != $past(dog_i, 2)
            || $past(dog_i, 2) != $past(dog_i, 3) || $past(dog_i, 3) != $past(dog_i, 4);
    endproperty
    a_latch_edge: assert property (p_latch_edge) else $error("latch without dog edge");
    property p_shift_creep;
        home_latch_o |-> ##[0:2] (speed_cmd_o == `DHS_SPD_CREEP || homing_fault_alarm_o);
    endproperty
    a_shift_creep: assert property (p_shift_creep) else $error("shift not at creep");
    property p_fault_stop;
        homing_fault_alarm_o && $past(homing_fault_alarm_o) |-> speed_cmd_o == `DHS_SPD_STOP;
    endproperty
    a_fault_stop: assert property (p_fault_stop) else $error("moving in fault");
    property p_done; st_rd && wb_dat_o[12] |-> wb_dat_o[10] && speed_cmd_o == `DHS_SPD_STOP; endproperty
    a_done: assert property (p_done) else $error("attained without target");
    property p_code; st_rd && wb_dat_o[13] |-> wb_dat_o[31:20] == `DHS_FAULT_CODE; endproperty
    a_code: assert property (p_code) else $error("bad fault code");
    c_latch: cover property (home_latch_o);
    c_fault: cover property ($rose(homing_fault_alarm_o));
    c_err: cover property (wb_err_o);
endmodule
bind dhs_sequencer dhs_sequencer_asserts #(.SHIFT_W(SHIFT_W)) u_chk (.*);

// ---- dv/dhs_machine_model.sv ----
`timescale 1ns/10ps
`include "dhs_consts.vh"
module dhs_machine_model #(
    parameter DOG_LO = 200
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // commands and setup
    input wire [1:0] speed_cmd_i,
    input wire dir_rev_i,
    input wire load_i,
    input wire [15:0] start_i,
    input wire [15:0] dog_hi_i,
    input wire [15:0] stroke_i,
    input wire [3:0] creep_lag_i,
    // feedback
    output wire dog_o,
    output wire stroke_end_o,
    output wire at_creep_o,
    output wire motion_done_o,
    output reg [15:0] travel_o,
    output reg [15:0] pos_o
);
    reg [3:0] lag_reg;
    wire [15:0] step = speed_cmd_i == `DHS_SPD_HOMING ? 16'h2 : {15'h0, speed_cmd_i == `DHS_SPD_CREEP};
    // axis moves 2 counts a cycle at homing speed, 1 at creep
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_o <= 16'h0;
            travel_o <= 16'h0;
            lag_reg <= 4'h0;
        end else begin
            pos_o <= load_i ? start_i : (dir_rev_i ? pos_o - step : pos_o + step);
            travel_o <= travel_o + step;
            lag_reg <= speed_cmd_i != `DHS_SPD_CREEP ? 4'h0 : lag_reg + {3'h0, lag_reg != 4'hf};
        end
    end
    // slow-down lag before creep is reported
    assign at_creep_o = speed_cmd_i == `DHS_SPD_CREEP && lag_reg >= creep_lag_i;
    assign dog_o = pos_o >= DOG_LO && pos_o <= dog_hi_i;
    assign stroke_end_o = pos_o >= stroke_i;
    assign motion_done_o = speed_cmd_i == `DHS_SPD_STOP;
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`include "dhs_consts.vh"
module tb;
    reg clk_i = 0, rst_n_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ld = 0, e;
    reg [7:0] wb_adr_i = 0;
    reg [3:0] wb_sel_i = 4'hf, lag = 0;
    reg [31:0] wb_dat_i = 0, q;
    reg [15:0] st = 0, hi = 0, sk = 16'hffff;
    wire [31:0] wb_dat_o;
    wire [15:0] travel_count_i, pos;
    wire [1:0] speed_cmd_o;
    wire wb_ack_o, wb_err_o, dog_i, stroke_end_i, at_creep_i, motion_done_i;
    wire dir_rev_o, home_latch_o, homing_fault_alarm_o;
    integer fails = 0, samples_checked = 0, i;
    // method codes and ideal end points, entry 0 in the low bits
    reg [47:0] mt = 48'hd8f8_d9f9_dafa;
    reg [95:0] ep = 96'h00bf_0135_0124_00d0_00bf_0135;
    // clock
    always #25 clk_i = ~clk_i;
    dhs_sequencer #(.SHIFT_W(16)) i_dhs_sequencer (.*);
    dhs_machine_model i_dhs_machine_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .speed_cmd_i(speed_cmd_o),
        .dir_rev_i(dir_rev_o), .load_i(ld), .start_i(st), .dog_hi_i(hi), .stroke_i(sk), .creep_lag_i(lag),
        .dog_o(dog_i), .stroke_end_o(stroke_end_i), .at_creep_o(at_creep_i), .motion_done_o(motion_done_i),
        .travel_o(travel_count_i), .pos_o(pos));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("fails=%0d samples_checked=%0d", fails, samples_checked);
            if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one classic cycle, held until ack or err
    task wb(input [7:0] a, input w, input [31:0] d);
        integer n;
        begin
            wb_cyc_i <= 1;
            wb_stb_i <= 1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            n = 0;
            // answer and read data taken at the rising edge that samples ack
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 9) begin
                @(posedge clk_i);
                n = n + 1;
            end
            q = wb_dat_o;
            e = wb_err_o;
            if (n == 9) fails = fails + 1;
            wb_cyc_i <= 0;
            wb_stb_i <= 0;
            @(posedge clk_i);
        end
    endtask
    // set up the axis, start homing, poll status, check end point
    task home(input [31:0] c, input [15:0] s, h, k, input [3:0] g, input [31:0] x, input [15:0] p);
        integer n;
        begin
            st <= s;
            hi <= h;
            sk <= k;
            lag <= g;
            ld <= 1;
            wb(`DHS_OFF_CTRL, 1, c);
            ld <= 0;
            wb(`DHS_OFF_CTRL, 1, c | 32'h10);
            n = 0;
            q = 0;
            while (q[13:12] == 2'h0 && n < 600) begin
                wb(`DHS_OFF_STAT, 0, 0);
                n = n + 1;
            end
            chk(q & 32'hfff0_3400, x);
            chk(homing_fault_alarm_o, x[13]);
            if (x[12]) chk(pos - p + 16'd8 <= 16'd16, 1);
            if (x[12]) begin
                wb(`DHS_OFF_MOTION, 0, 0);
                chk(q[15:0] - 16'd8 <= 16'd8, 1);
            end
        end
    endtask
    // watchdog
    initial begin
        #(50 * 40000);
        fails = fails + 1;
        report_and_stop;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1;
        @(posedge clk_i);
        wb(`DHS_OFF_CTRL, 0, 0);
        chk(q, `DHS_CTRL_RESET_VAL);
        wb(`DHS_OFF_STAT, 0, 0);
        chk(q, 0);
        wb(`DHS_OFF_CTRL, 1, 32'hffff_0000);
        wb(`DHS_OFF_CTRL, 0, 0);
        chk(q, 32'h0001_0000);
        wb(8'h10, 0, 0);
        chk(e, 1);
        wb(`DHS_OFF_SHIFT, 1, 8);
        wb(`DHS_OFF_SHIFT, 0, 0);
        chk(q, 8);
        for (i = 0; i < 6; i = i + 1) begin
            home({16'h0, mt[i*8 +: 8], 8'h0}, mt[i*8+5] ? 100 : 400, 300, 16'hffff, 2, 32'h1400, ep[i*16 +: 16]);
        end
        home(32'hfa00, 250, 300, 16'hffff, 2, 32'h1400, 309);
        home(32'hfa00, 350, 300, 500, 2, 32'h1400, 309);
        home(32'h1_fa00, 350, 300, 500, 2, 32'h0900_2400, 0);
        home(32'hfa00, 100, 203, 16'hffff, 15, 32'h0900_2400, 0);
        report_and_stop;
    end
endmodule
